/* design/serial_boot_download_loader.sv */
/*
  Serial bootstrap download loader: sets up the serial port, picks the
  baud rate from the first character, loads a program into RAM with echo,
  and hands control to RAM or nonvolatile memory.
  Assumes the serial receive pin is synchronous to clk_sys_i, an external
  pull-up on the transmit pin, and a RAM that takes one write per pulse.
*/

// Summary of operation
// - after init the port runs at 7812 baud; 1200 baud is the alternate.
// - host opens with an all-ones byte; its reception picks the session rate.
// - receiver finds start edge, checks mid start, samples mid-bit, checks stop.
// - first byte FF keeps fast rate; E0 or C0 switches to 1200 baud.
// - init enables both the serial receiver and transmitter.
// - init selects open-drain pins; transmit pin never drives high.
// - after init send one break; first byte 00 jumps to B600.
// - with rate settled, RAM write pointer starts at 0000.
// - program length may be anything from 0 to 512 bytes.
// - download ends after four idle character times following the last byte.
// - fast-rate timeout is 539 passes of a 19-cycle step, 10,241 cycles.
// - switching to 1200 baud also lengthens the timeout constant.
// - no timeout runs before the first byte arrives.
// - timeout restarts for each expected byte; wait for byte or expiry.
// - each byte is stored at the pointer; pointer increments as its echo is requested.
// - stop on timeout or full RAM, then run from the start of RAM.
// - all-ones byte alone jumps to RAM start with nothing stored.
// - option for 256-byte RAM: fixed 256 bytes, no idle timeout.

`include "serial_boot_map.svh"

module serial_boot_download_loader #(
  parameter int RAM_BYTES     = `SBL_RAM_BYTES,
  parameter bit FIXED_LEN     = 1'b0,
  parameter int FIXED_BYTES   = `SBL_FIXED_BYTES,
  parameter int E_DIV         = `SBL_E_DIV,
  parameter int TO_STEP_E     = `SBL_TO_STEP_E,
  parameter int TO_PASS_FAST  = `SBL_TO_PASS_FAST,
  parameter int TO_PASS_SLOW  = `SBL_TO_PASS_SLOW,
  parameter int FAST_BIT_CLKS = `SBL_FAST_BIT_E * `SBL_E_DIV,
  parameter int SLOW_BIT_CLKS = `SBL_SLOW_BIT_E * `SBL_E_DIV
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rstn_i,
  input  wire logic                  serial_receive_pin_i,
  output logic                       serial_transmit_pin_o,
  output logic                       serial_transmit_pin_oe_o,
  output logic                       port_open_drain_select_o,
  output logic                       serial_rx_enable_o,
  output logic                       serial_tx_enable_o,
  output serial_boot_pkg::ram_wr_t   ram_wr_o,
  output logic                       run_o,
  output logic [15:0]                run_addr_o,
  output logic                       rate_slow_o,
  output logic                       rx_frame_err_o
);

  localparam int BIT_W  = 16;
  localparam int PASS_W = 12;
  localparam int PTR_W  = $clog2(RAM_BYTES) + 1;
  localparam logic [PTR_W-1:0] LIMIT =
    PTR_W'(FIXED_LEN ? FIXED_BYTES : RAM_BYTES);

  serial_boot_pkg::loader_state_t st_r;
  serial_boot_pkg::rx_byte_t      rx_byte;
  logic                           rx_valid;
  logic                           tx_busy;
  logic                           tx_pull_low;
  logic [BIT_W-1:0]               bit_len;
  logic                           tx_start_r;
  logic                           tx_break_r;
  logic [7:0]                     echo_r;
  logic [PTR_W-1:0]               ptr_r;
  logic [$clog2(E_DIV+1)-1:0]     e_cnt_r;
  logic                           e_tick_r;
  logic [4:0]                     step_r;
  logic [PASS_W-1:0]              pass_r;
  logic                           to_load_r;
  logic                           to_expired;

  // rate select feeds both serial halves
  assign bit_len = rate_slow_o ? BIT_W'(SLOW_BIT_CLKS) : BIT_W'(FAST_BIT_CLKS);

  async_serial_rx #(
    .BIT_W (BIT_W)
  ) u_rx (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .en_i      (serial_rx_enable_o),
    .rxd_i     (serial_receive_pin_i),
    .bit_len_i (bit_len),
    .rx_o      (rx_byte),
    .valid_o   (rx_valid)
  );

  async_serial_tx #(
    .BIT_W (BIT_W)
  ) u_tx (
    .clk_sys_i  (clk_sys_i),
    .rstn_i     (rstn_i),
    .en_i       (serial_tx_enable_o),
    .start_i    (tx_start_r),
    .break_i    (tx_break_r),
    .data_i     (echo_r),
    .bit_len_i  (bit_len),
    .pull_low_o (tx_pull_low),
    .busy_o     (tx_busy)
  );

  // open drain: the data level is always low, only the enable moves
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_transmit_pin_o    <= 1'b0;
      serial_transmit_pin_oe_o <= 1'b0;
    end else begin
      serial_transmit_pin_o    <= 1'b0;
      serial_transmit_pin_oe_o <= tx_pull_low && port_open_drain_select_o;
    end
  end

  // bus-clock tick, the unit of the timeout
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      e_cnt_r  <= '0;
      e_tick_r <= 1'b0;
    end else if (e_cnt_r == ($bits(e_cnt_r))'(E_DIV - 1)) begin
      e_cnt_r  <= '0;
      e_tick_r <= 1'b1;
    end else begin
      e_cnt_r  <= e_cnt_r + 1'b1;
      e_tick_r <= 1'b0;
    end
  end

  // inter-character timeout: pass counter over a 19-tick step
  assign to_expired = (pass_r == '0);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      step_r <= 5'h00;
      pass_r <= '0;
    end else if (to_load_r) begin
      step_r <= 5'(TO_STEP_E - 1);
      pass_r <= rate_slow_o ? PASS_W'(TO_PASS_SLOW) : PASS_W'(TO_PASS_FAST);
    end else if (st_r == serial_boot_pkg::ST_WAIT && !FIXED_LEN && e_tick_r
                 && !to_expired) begin
      if (step_r == 5'h00) begin
        step_r <= 5'(TO_STEP_E - 1);
        pass_r <= pass_r - 1'b1;
      end else begin
        step_r <= step_r - 5'h01;
      end
    end
  end

  // main sequence
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r                     <= serial_boot_pkg::ST_INIT;
      port_open_drain_select_o <= 1'b0;
      serial_rx_enable_o       <= 1'b0;
      serial_tx_enable_o       <= 1'b0;
      rate_slow_o              <= 1'b0;
      echo_r                   <= 8'h00;
      to_load_r                <= 1'b0;
      run_o                    <= 1'b0;
      run_addr_o               <= `SBL_RAM_START;
    end else begin
      to_load_r <= 1'b0;
      case (st_r)
        serial_boot_pkg::ST_INIT: begin
          port_open_drain_select_o <= 1'b1;
          serial_rx_enable_o       <= 1'b1;
          serial_tx_enable_o       <= 1'b1;
          rate_slow_o              <= 1'b0;
          st_r                     <= serial_boot_pkg::ST_BREAK;
        end
        serial_boot_pkg::ST_BREAK: begin
          st_r <= serial_boot_pkg::ST_FIRST;
        end
        serial_boot_pkg::ST_FIRST: begin
          // no timeout here: the host may take as long as it likes
          if (rx_valid) begin
            if (rx_byte.data == `SBL_CODE_LOOPBACK) begin
              run_addr_o <= `SBL_NVM_START;
              st_r       <= serial_boot_pkg::ST_RUN;
            end else begin
              if (rx_byte.data == `SBL_CODE_SLOW_A
                  || rx_byte.data == `SBL_CODE_SLOW_B) begin
                rate_slow_o <= 1'b1;
              end
              to_load_r <= 1'b1;
              st_r      <= serial_boot_pkg::ST_WAIT;
            end
          end
        end
        serial_boot_pkg::ST_WAIT: begin
          if (rx_valid) begin
            echo_r <= rx_byte.data;
            st_r          <= serial_boot_pkg::ST_ECHO;
          end else if (!FIXED_LEN && to_expired && !to_load_r) begin
            run_addr_o <= `SBL_RAM_START;
            st_r       <= serial_boot_pkg::ST_RUN;
          end
        end
        serial_boot_pkg::ST_ECHO: begin
          // waits for the transmitter before taking the next byte
          if (!tx_busy) begin
            if (ptr_r + 1'b1 == LIMIT) begin
              run_addr_o <= `SBL_RAM_START;
              st_r       <= serial_boot_pkg::ST_RUN;
            end else begin
              to_load_r <= 1'b1;
              st_r      <= serial_boot_pkg::ST_WAIT;
            end
          end
        end
        serial_boot_pkg::ST_RUN: begin
          // serial port stays on so the last echo still leaves
          run_o <= 1'b1;
        end
        default: begin
          st_r <= serial_boot_pkg::ST_INIT;
        end
      endcase
    end
  end

  // transmit requests: one break after init, then one echo per stored byte
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_start_r <= 1'b0;
      tx_break_r <= 1'b0;
    end else begin
      tx_start_r <= 1'b0;
      tx_break_r <= 1'b0;
      if (st_r == serial_boot_pkg::ST_BREAK) begin
        tx_start_r <= 1'b1;
        tx_break_r <= 1'b1;
      end else if (st_r == serial_boot_pkg::ST_ECHO && !tx_busy) begin
        tx_start_r <= 1'b1;
      end
    end
  end

  // RAM write pointer
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ptr_r <= '0;
    end else if (st_r == serial_boot_pkg::ST_FIRST && rx_valid
                 && rx_byte.data != `SBL_CODE_LOOPBACK) begin
      ptr_r <= '0;
    end else if (st_r == serial_boot_pkg::ST_ECHO && !tx_busy) begin
      ptr_r <= ptr_r + 1'b1;
    end
  end

  // RAM write port: strobe lasts one cycle, address and data stay
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ram_wr_o <= '0;
    end else begin
      ram_wr_o.we <= 1'b0;
      if (st_r == serial_boot_pkg::ST_WAIT && rx_valid) begin
        ram_wr_o.we   <= 1'b1;
        ram_wr_o.addr <= 16'(ptr_r);
        ram_wr_o.data <= rx_byte.data;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_frame_err_o <= 1'b0;
    end else if (rx_valid) begin
      rx_frame_err_o <= rx_byte.frame_err;
    end
  end

endmodule // serial_boot_download_loader

/* include/serial_boot_map.svh */
/*
  Constants of the serial bootstrap loader: timing figures, first-byte
  codes and jump targets. Assumes nothing; definitions only.
*/
`ifndef SERIAL_BOOT_MAP_SVH
`define SERIAL_BOOT_MAP_SVH

// clocks
`define SBL_SYS_CLK_HZ      20000000
`define SBL_E_CLK_HZ        2000000
`define SBL_E_DIV           (`SBL_SYS_CLK_HZ / `SBL_E_CLK_HZ)

// bit times in bus (E) cycles: 4 x 4 x 16 for 7812 baud, 13 x 8 x 16 for 1200
`define SBL_FAST_BIT_E      256
`define SBL_SLOW_BIT_E      1664

// inter-character timeout: passes of a 19 E-cycle wait step
`define SBL_TO_STEP_E       19
`define SBL_TO_PASS_FAST    539
`define SBL_TO_PASS_SLOW    3504

// first character codes
`define SBL_CODE_ONES       8'hFF
`define SBL_CODE_SLOW_A     8'hE0
`define SBL_CODE_SLOW_B     8'hC0
`define SBL_CODE_LOOPBACK   8'h00

// jump targets and RAM
`define SBL_RAM_START       16'h0000
`define SBL_NVM_START       16'hB600
`define SBL_RAM_BYTES       512
`define SBL_FIXED_BYTES     256

// serial frame lengths in bits
`define SBL_FRAME_BITS      4'hA
`define SBL_BREAK_BITS      4'hB

`endif

/* include/serial_boot_pkg.sv */
/*
  Types shared by the serial bootstrap loader and its serial receive half.
  Assumes serial_boot_map.svh for the numbers.
*/
package serial_boot_pkg;

  typedef enum logic [5:0] {
    ST_INIT  = 6'h01,
    ST_BREAK = 6'h02,
    ST_FIRST = 6'h04,
    ST_WAIT  = 6'h08,
    ST_ECHO  = 6'h10,
    ST_RUN   = 6'h20
  } loader_state_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } rx_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic       frame_err;
  } rx_byte_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } ram_wr_t;

endpackage

/* design/async_serial_rx.sv */
/*
  Receive half of the asynchronous serial port: start edge, mid-bit start
  check, eight data bits LSB first, stop-bit framing check.
  Assumes rxd_i synchronous to clk_sys_i and bit_len_i stable while busy.
*/
module async_serial_rx #(
  parameter int BIT_W = 16
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rstn_i,
  input  wire logic                     en_i,
  input  wire logic                     rxd_i,
  input  wire logic [BIT_W-1:0]         bit_len_i,
  output serial_boot_pkg::rx_byte_t     rx_o,
  output logic                          valid_o
);

  serial_boot_pkg::rx_state_t st_r;
  logic [BIT_W-1:0] cnt_r;
  logic [2:0]       idx_r;
  logic [7:0]       sh_r;
  logic             prev_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= rxd_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r    <= serial_boot_pkg::RX_IDLE;
      cnt_r   <= '0;
      idx_r   <= 3'h0;
      sh_r    <= 8'h00;
      rx_o    <= '0;
      valid_o <= 1'b0;
    end else begin
      valid_o <= 1'b0;
      case (st_r)
        serial_boot_pkg::RX_IDLE: begin
          if (en_i && prev_r && !rxd_i) begin
            cnt_r <= bit_len_i >> 1;
            st_r  <= serial_boot_pkg::RX_START;
          end
        end
        serial_boot_pkg::RX_START: begin
          if (cnt_r == '0) begin
            // a glitch shorter than half a bit is dropped here
            if (!rxd_i) begin
              cnt_r <= bit_len_i - 1'b1;
              idx_r <= 3'h0;
              st_r  <= serial_boot_pkg::RX_DATA;
            end else begin
              st_r <= serial_boot_pkg::RX_IDLE;
            end
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        serial_boot_pkg::RX_DATA: begin
          if (cnt_r == '0) begin
            sh_r  <= {rxd_i, sh_r[7:1]};
            idx_r <= idx_r + 3'h1;
            cnt_r <= bit_len_i - 1'b1;
            if (idx_r == 3'h7) begin
              st_r <= serial_boot_pkg::RX_STOP;
            end
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        serial_boot_pkg::RX_STOP: begin
          if (cnt_r == '0) begin
            rx_o.data      <= sh_r;
            rx_o.frame_err <= !rxd_i;
            valid_o        <= 1'b1;
            st_r           <= serial_boot_pkg::RX_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          st_r <= serial_boot_pkg::RX_IDLE;
        end
      endcase
    end
  end

endmodule // async_serial_rx

/* design/async_serial_tx.sv */
/*
  Transmit half of the asynchronous serial port, open-drain style: the pin
  is only ever pulled low. Sends a 10-bit frame or a break (ten low bits
  then a stop bit). Assumes start_i is a one-cycle pulse while idle.
*/
`include "serial_boot_map.svh"

module async_serial_tx #(
  parameter int BIT_W = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rstn_i,
  input  wire logic             en_i,
  input  wire logic             start_i,
  input  wire logic             break_i,
  input  wire logic [7:0]       data_i,
  input  wire logic [BIT_W-1:0] bit_len_i,
  output logic                  pull_low_o,
  output logic                  busy_o
);

  logic [10:0]      frame_r;
  logic [BIT_W-1:0] cnt_r;
  logic [3:0]       left_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_r    <= 11'h7FF;
      cnt_r      <= '0;
      left_r     <= 4'h0;
      busy_o     <= 1'b0;
      pull_low_o <= 1'b0;
    end else if (!busy_o) begin
      if (en_i && start_i) begin
        frame_r    <= break_i ? 11'h400 : {2'b11, data_i, 1'b0};
        left_r     <= (break_i ? `SBL_BREAK_BITS : `SBL_FRAME_BITS) - 4'h1;
        cnt_r      <= bit_len_i - 1'b1;
        busy_o     <= 1'b1;
        pull_low_o <= 1'b1;
      end
    end else if (cnt_r == '0) begin
      if (left_r == 4'h0) begin
        busy_o     <= 1'b0;
        pull_low_o <= 1'b0;
      end else begin
        frame_r    <= {1'b1, frame_r[10:1]};
        pull_low_o <= !frame_r[1];
        left_r     <= left_r - 4'h1;
        cnt_r      <= bit_len_i - 1'b1;
      end
    end else begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule // async_serial_tx

/* bench/serial_boot_checker.sv */
/* Port checker of the serial boot loader, bound into every instance.
   Assumes rstn_i asynchronous and active low. */
module serial_boot_checker #(
  parameter int RAM_BYTES = 512
) (
  input wire logic                     clk_sys_i,
  input wire logic                     rstn_i,
  input wire logic                     serial_transmit_pin_o,
  input wire logic                     port_open_drain_select_o,
  input wire logic                     serial_rx_enable_o,
  input wire logic                     serial_tx_enable_o,
  input wire serial_boot_pkg::ram_wr_t ram_wr_o,
  input wire logic                     run_o,
  input wire logic [15:0]              run_addr_o,
  input wire logic                     rate_slow_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] wr_cnt_r;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  // writes since reset: the offset the next write must use
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_cnt_r <= 16'h0000;
    end else if (ram_wr_o.we) begin
      wr_cnt_r <= wr_cnt_r + 16'h0001;
    end
  end

  a_port_setup: assert property (
    $past(rstn_i) |-> port_open_drain_select_o && serial_rx_enable_o && serial_tx_enable_o)
    else $error("serial port not set up after reset");
  a_tx_never_high: assert property (
    serial_transmit_pin_o == 1'b0)
    else $error("transmit pin driven high");
  a_write_pulse: assert property (
    ram_wr_o.we |=> !ram_wr_o.we)
    else $error("write strobe longer than one cycle");
  a_write_order: assert property (
    ram_wr_o.we |-> ram_wr_o.addr == wr_cnt_r)
    else $error("write address out of sequence");
  a_ram_limit: assert property (
    ram_wr_o.we |-> wr_cnt_r < RAM_BYTES)
    else $error("write beyond end of RAM");
  a_run_holds: assert property (
    run_o |=> run_o && $stable(run_addr_o))
    else $error("run state not held");
  a_run_no_write: assert property (
    run_o |-> !ram_wr_o.we)
    else $error("write after loading ended");
  a_run_target: assert property (
    run_o |-> run_addr_o == 16'h0000 || (run_addr_o == 16'hB600 && wr_cnt_r == 16'h0000))
    else $error("bad jump target");
  a_full_stops: assert property (
    !rate_slow_o && wr_cnt_r == RAM_BYTES |-> ##[0:1000] run_o)
    else $error("full RAM did not end loading");
  a_rate_locked: assert property (
    $changed(rate_slow_o) |-> $rose(rate_slow_o) && wr_cnt_r == 16'h0000 && !run_o)
    else $error("rate changed after first byte");
endmodule // serial_boot_checker

bind serial_boot_download_loader serial_boot_checker #(.RAM_BYTES(RAM_BYTES)) chk (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .serial_transmit_pin_o(serial_transmit_pin_o),
  .port_open_drain_select_o(port_open_drain_select_o),
  .serial_rx_enable_o(serial_rx_enable_o), .serial_tx_enable_o(serial_tx_enable_o),
  .ram_wr_o(ram_wr_o), .run_o(run_o), .run_addr_o(run_addr_o), .rate_slow_o(rate_slow_o)
);

/* bench/serial_host_model.sv */
/* Host on the far side of the serial pins: sends 8N1 characters and
   collects returned frames. Assumes a pull-up on the returned line. */
module serial_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        line_i,
  input  wire logic [15:0] echo_bit_i,
  output logic             txd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] echo_q[$];

  initial txd_o = 1'b1;

  // lsb first; left high afterwards as the idle level
  task automatic send_byte(input logic [7:0] b, input int bit_clks);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys_i);
      txd_o = frame[i];
      repeat (bit_clks - 1) @(negedge clk_sys_i);
    end
  endtask

  // mid-bit samples, stop in bit 8; a break shows as all low
  always begin : grab
    logic [8:0] f;
    @(negedge line_i);
    repeat (echo_bit_i / 2) @(posedge clk_sys_i);
    for (int i = 0; i < 9; i++) begin
      repeat (echo_bit_i) @(posedge clk_sys_i);
      f[i] = line_i;
    end
    echo_q.push_back(f);
  end
endmodule // serial_host_model

/* bench/testbench.sv */
/* Self-checking bench of the serial boot loader with a host model.
   Assumes package and design compiled first; counts are shortened. */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FB = 40;
  localparam int SB = 260;
  localparam int RB = 8;
  localparam int TO_F = 43 * 19 * 2;
  localparam int TO_S = 274 * 19 * 2;

  logic                     clk_sys_i;
  logic                     rstn_i;
  logic                     rxd;
  logic                     tx_pin;
  logic                     tx_oe;
  logic                     run;
  logic [15:0]              run_addr;
  logic                     rate_slow;
  logic                     frame_err;
  logic [15:0]              echo_bit;
  serial_boot_pkg::ram_wr_t ram_wr;
  wire                      tx_line;
  logic [23:0]              wr_q[$];
  logic [31:0]              seed;
  int                       err_total;
  int                       checks;

  assign tx_line = tx_oe ? tx_pin : 1'b1;
  initial clk_sys_i = 1'b0;
  always #25 clk_sys_i = ~clk_sys_i;

  serial_boot_download_loader #(
    .RAM_BYTES(RB), .E_DIV(2), .TO_PASS_FAST(43), .TO_PASS_SLOW(274),
    .FAST_BIT_CLKS(FB), .SLOW_BIT_CLKS(SB)
  ) uut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .serial_receive_pin_i(rxd),
    .serial_transmit_pin_o(tx_pin), .serial_transmit_pin_oe_o(tx_oe),
    .port_open_drain_select_o(), .serial_rx_enable_o(), .serial_tx_enable_o(),
    .ram_wr_o(ram_wr), .run_o(run), .run_addr_o(run_addr), .rate_slow_o(rate_slow),
    .rx_frame_err_o(frame_err)
  );

  serial_host_model host (
    .clk_sys_i(clk_sys_i), .line_i(tx_line), .echo_bit_i(echo_bit), .txd_o(rxd)
  );

  // sampled mid-cycle, away from the edge that launches the strobe
  always @(negedge clk_sys_i) begin
    if (ram_wr.we === 1'b1) begin
      wr_q.push_back({ram_wr.addr, ram_wr.data});
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // cycles from end of the last character to run, lower edge
  function automatic int run_lo(input logic [7:0] code, input logic slow, input int n);
    if (n == RB || code == 8'h00) return 0;
    return (slow ? TO_S : TO_F) - (slow ? SB : FB) / 2 - 6;
  endfunction

  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic session(input logic [7:0] code, input int fbit, input logic slow,
                         input int n, input logic [15:0] target, input int pre);
    logic [7:0] sent[$];
    int b;
    int lo;
    int d;
    b = slow ? SB : FB;
    @(negedge clk_sys_i);
    rstn_i = 1'b0;
    echo_bit = 16'(FB);
    wr_q.delete();
    host.echo_q.delete();
    repeat (2) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (12 * FB + pre) @(negedge clk_sys_i);
    check_val("run before first byte", 16'h0000, 16'(run));
    host.send_byte(code, fbit);
    echo_bit = 16'(b);
    for (int k = 0; k < n; k++) begin
      seed = lfsr_next(seed);
      sent.push_back(seed[7:0]);
      // pause well inside the timeout: loading must go on
      if (k == 2) repeat (25 * b) @(negedge clk_sys_i);
      host.send_byte(seed[7:0], b);
    end
    lo = run_lo(code, slow, n);
    d = 0;
    while (run !== 1'b1 && d < 20000) begin
      @(negedge clk_sys_i);
      d++;
    end
    if (d >= 20000) begin
      err_total++;
      $display("unexpected run wait: expected 1, seen %b", run);
      report_and_stop();
    end
    check_val("run delay", 16'h0001, 16'(d >= lo && d <= lo + (lo == 0 ? 2 * b : 18)));
    repeat (12 * b) @(negedge clk_sys_i);
    check_val("jump target", target, run_addr);
    check_val("slow rate", 16'(slow), 16'(rate_slow));
    check_val("frame error", 16'h0000, 16'(frame_err));
    check_val("writes", 16'(n), 16'(wr_q.size()));
    check_val("break echo", 16'h0000, 16'(host.echo_q[0]));
    check_val("echo count", 16'(n + 1), 16'(host.echo_q.size()));
    for (int k = 0; k < n; k++) begin
      check_val("write address", 16'(k), wr_q[k][23:8]);
      check_val("write data", 16'(sent[k]), 16'(wr_q[k][7:0]));
      check_val("echo", {7'h00, 1'b1, sent[k]}, 16'(host.echo_q[k + 1]));
    end
    $display("test done: first byte %h, %0d data bytes", code, n);
  endtask

  initial begin
    rstn_i = 1'b0;
    echo_bit = 16'(FB);
    err_total = 0;
    checks = 0;
    seed = 32'h0001_6414;
    session(8'h00, FB, 1'b0, 0, 16'hB600, 0);
    session(8'hFF, FB, 1'b0, 0, 16'h0000, 3000);
    session(8'hFF, FB, 1'b0, 5, 16'h0000, 0);
    session(8'hFF, FB, 1'b0, RB, 16'h0000, 0);
    session(8'hE0, FB, 1'b1, 2, 16'h0000, 0);
    session(8'hC0, FB, 1'b1, 2, 16'h0000, 0);
    session(8'hFF, SB, 1'b1, 2, 16'h0000, 0);
    report_and_stop();
  end
endmodule // testbench
